//--- inc/sdram_mode_regs.vh
// mode setting field layout, command encodings and timing constants
`ifndef SDRAM_MODE_REGS_VH
`define SDRAM_MODE_REGS_VH
`define SETTING_W 12
`define SETTING_RESET 12'h020
`define BL_LSB 0
`define BL_MSB 2
`define BO_BIT 3
`define LAT_LSB 4
`define LAT_MSB 6
`define WM_LSB 8
`define WM_MSB 11
`define BL_1 3'h0
`define BL_2 3'h1
`define BL_4 3'h2
`define BL_8 3'h3
`define BL_PAGE 3'h7
`define LAT_2 3'h2
`define LAT_3 3'h3
`define WM_BURST 3'h0
`define WM_SINGLE 3'h4
`define CMD_NOP 3'h7
`define CMD_ACT 3'h3
`define CMD_READ 3'h5
`define CMD_WRITE 3'h4
`define CMD_PRE 3'h2
`define CMD_REF 3'h1
`define CMD_MODE 3'h0
`define CMD_BST 3'h6
`define PRE_ALL_BIT 10
`define BANK_BIT 11
`define HOLD_US 100
`define CLK_MHZ 100
`define HOLD_CYCLES (`HOLD_US * `CLK_MHZ)
`define MODE_GAP_CYCLES 2
`define PAGE_LEN 256
`endif

//--- core/burst_addr_gen.v
// column address generator for one burst beat
`include "sdram_mode_regs.vh"
module burst_addr_gen
(
   input wire [7:0] START_COL,
   input wire [7:0] BEAT,
   input wire [2:0] LEN_CODE,
   input wire INTERLEAVE,
   output reg [7:0] COL
);
   reg [7:0] wrap_mask;
   // sequential wraps inside the burst window, interleaved xors the beat
   always @*
   begin
      wrap_mask = 8'h00;
      case (LEN_CODE)
         `BL_2: wrap_mask = 8'h01;
         `BL_4: wrap_mask = 8'h03;
         `BL_8: wrap_mask = 8'h07;
         `BL_PAGE: wrap_mask = 8'hFF;
         default: wrap_mask = 8'h00;
      endcase
      if (INTERLEAVE)
         COL = START_COL ^ (BEAT & wrap_mask);
      else
         COL = (START_COL & ~wrap_mask) | ((START_COL + BEAT) & wrap_mask);
   end
endmodule // burst_addr_gen

//--- core/sdram_mode_ctrl.v
// command decode, mode setting and burst sequencing of the two-bank sdram
// Behaviour
// - mode load accepted before or after refresh
// - mode load latches twelve address pins
// - setting split into four fields
// - read data after programmed latency two or three only
// - burst length decode, reserved codes
// - burst columns generated internally
// - sequential or interleaved burst order
// - write bits zero give burst writes
// - write bits 100 give single writes
// - precharge bit10 all, else bank11
`include "sdram_mode_regs.vh"
module sdram_mode_ctrl
#(
   parameter HOLD_CYCLES = `HOLD_CYCLES
)
(
   input wire CLK,
   input wire ARST_N,
   input wire CKE,
   input wire CS_N,
   input wire RAS_N,
   input wire CAS_N,
   input wire WE_N,
   input wire [11:0] ADDRESS_PINS,
   output reg INIT_DONE,
   output reg [11:0] SETTING_VALUE,
   output reg [2:0] BURST_COUNT_FIELD,
   output reg BURST_ORDER_FIELD,
   output reg [2:0] READ_LATENCY_FIELD,
   output reg [3:0] WRITE_MODE_FIELD,
   output reg [1:0] BANK_OPEN,
   output reg COL_VALID,
   output reg COL_WRITE,
   output reg COL_BANK,
   output reg [7:0] COL_ADDR,
   output reg DATA_OUT_EN,
   output reg SEQ_ERROR
);
   ////////////////////////////////////////////////////////////////////////
   localparam ST_HOLD = 3'h0;
   localparam ST_WAIT_PRE = 3'h1;
   localparam ST_INIT = 3'h2;
   localparam ST_READY = 3'h3;
   // post-load gap length, cut to the width of its counter
   localparam GAP = `MODE_GAP_CYCLES;

   reg [2:0] state_q;
   reg [16:0] hold_q;
   reg [1:0] ref_cnt_q;
   reg mode_seen_q;
   reg [1:0] gap_q;
   reg burst_q;
   reg burst_wr_q;
   reg burst_bank_q;
   reg [7:0] start_q;
   reg [7:0] beat_q;
   reg [8:0] last_beat_q;
   reg [1:0] rd_pipe_q;
   wire [2:0] cmd;
   wire [7:0] gen_col;
   wire mode_cmd;
   wire [8:0] blen;

   // beats per length code, reserved as one
   function [8:0] beats;
      input [2:0] code;
      input interleave;
      begin
         case (code)
            `BL_1: beats = 9'h001;
            `BL_2: beats = 9'h002;
            `BL_4: beats = 9'h004;
            `BL_8: beats = 9'h008;
            `BL_PAGE: beats = interleave ? 9'h001 : 9'h100;
            default: beats = 9'h001;
         endcase
      end
   endfunction

   // deselect and suspended cycles decode as no operation
   assign cmd = (CS_N || !CKE) ? `CMD_NOP : {RAS_N, CAS_N, WE_N};
   assign mode_cmd = (cmd == `CMD_MODE);
   assign blen = beats(BURST_COUNT_FIELD, BURST_ORDER_FIELD);

   burst_addr_gen u_gen
   (
      .START_COL(start_q),
      .BEAT(beat_q),
      .LEN_CODE(BURST_COUNT_FIELD),
      .INTERLEAVE(BURST_ORDER_FIELD),
      .COL(gen_col)
   );

   ////////////////////////////////////////////////////////////////////////
   // initialization tracker; the controller owns the hold, we only watch it
   always @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         state_q <= ST_HOLD;
         hold_q <= 17'h00000;
         ref_cnt_q <= 2'h0;
         mode_seen_q <= 1'b0;
         INIT_DONE <= 1'b0;
      end
      else
      begin
         INIT_DONE <= (state_q == ST_READY);
         case (state_q)
            // count hold time before any command
            ST_HOLD:
            begin
               if (hold_q < HOLD_CYCLES[16:0])
                  hold_q <= hold_q + 17'h00001;
               else
                  state_q <= ST_WAIT_PRE;
            end
            ST_WAIT_PRE:
            begin
               if (cmd == `CMD_PRE && ADDRESS_PINS[`PRE_ALL_BIT])
                  state_q <= ST_INIT;
            end
            // count refreshes; mode load in either order
            ST_INIT:
            begin
               if (cmd == `CMD_REF && ref_cnt_q != 2'h2)
                  ref_cnt_q <= ref_cnt_q + 2'h1;
               if (mode_cmd)
                  mode_seen_q <= 1'b1;
               if ((ref_cnt_q == 2'h2 || cmd == `CMD_REF && ref_cnt_q == 2'h1) && (mode_seen_q || mode_cmd))
                  state_q <= ST_READY;
            end
            ST_READY: state_q <= ST_READY;
            default: state_q <= ST_HOLD;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mode setting register and bank state
   always @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         SETTING_VALUE <= `SETTING_RESET;
         BURST_COUNT_FIELD <= `BL_1;
         BURST_ORDER_FIELD <= 1'b0;
         READ_LATENCY_FIELD <= `LAT_2;
         WRITE_MODE_FIELD <= 4'h0;
         BANK_OPEN <= 2'b00;
         gap_q <= 2'h0;
         SEQ_ERROR <= 1'b0;
      end
      else
      begin
         if (gap_q != 2'h0)
            gap_q <= gap_q - 2'h1;
         // flag a command inside the post-load gap
         if (gap_q != 2'h0 && cmd != `CMD_NOP)
            SEQ_ERROR <= 1'b1;
         // mode load with an open row is flagged
         if (mode_cmd && BANK_OPEN != 2'b00)
            SEQ_ERROR <= 1'b1;
         // latch address pins; split into fields
         if (mode_cmd)
         begin
            SETTING_VALUE <= ADDRESS_PINS;
            BURST_COUNT_FIELD <= ADDRESS_PINS[`BL_MSB:`BL_LSB];
            BURST_ORDER_FIELD <= ADDRESS_PINS[`BO_BIT];
            READ_LATENCY_FIELD <= ADDRESS_PINS[`LAT_MSB:`LAT_LSB];
            WRITE_MODE_FIELD <= ADDRESS_PINS[`WM_MSB:`WM_LSB];
            gap_q <= GAP[1:0];
         end
         if (cmd == `CMD_ACT)
            BANK_OPEN[ADDRESS_PINS[`BANK_BIT]] <= 1'b1;
         // precharge all or the selected bank
         if (cmd == `CMD_PRE)
         begin
            if (ADDRESS_PINS[`PRE_ALL_BIT])
               BANK_OPEN <= 2'b00;
            else
               BANK_OPEN[ADDRESS_PINS[`BANK_BIT]] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // burst sequencer; a new read or write cuts the running burst
   always @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         burst_q <= 1'b0;
         burst_wr_q <= 1'b0;
         burst_bank_q <= 1'b0;
         start_q <= 8'h00;
         beat_q <= 8'h00;
         last_beat_q <= 9'h000;
      end
      else if (cmd == `CMD_READ || cmd == `CMD_WRITE)
      begin
         // column sampled with the command is the start
         start_q <= ADDRESS_PINS[7:0];
         burst_bank_q <= ADDRESS_PINS[`BANK_BIT];
         burst_wr_q <= (cmd == `CMD_WRITE);
         beat_q <= 8'h00;
         burst_q <= 1'b1;
         // single write ignores the length; burst write uses it
         if (cmd == `CMD_WRITE && WRITE_MODE_FIELD[3:1] == `WM_SINGLE)
            last_beat_q <= 9'h000;
         else
            last_beat_q <= blen - 9'h001;
      end
      else if (burst_q)
      begin
         // stop on last beat, on burst stop or on precharge
         if ({1'b0, beat_q} == last_beat_q || cmd == `CMD_BST || cmd == `CMD_PRE)
            burst_q <= 1'b0;
         beat_q <= beat_q + 8'h01;
      end
   end

   // column registered one edge after its beat; writes start like reads, one edge after the command is sampled
   always @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         COL_VALID <= 1'b0;
         COL_WRITE <= 1'b0;
         COL_BANK <= 1'b0;
         COL_ADDR <= 8'h00;
      end
      else
      begin
         COL_VALID <= burst_q;
         COL_WRITE <= burst_wr_q;
         COL_BANK <= burst_bank_q;
         // order chosen by the burst order field
         COL_ADDR <= gen_col;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read beats delayed so the first appears latency cycles after read, for latency two or three only
   always @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         rd_pipe_q <= 2'h0;
         DATA_OUT_EN <= 1'b0;
      end
      else
      begin
         rd_pipe_q <= {rd_pipe_q[0], burst_q & ~burst_wr_q};
         case (READ_LATENCY_FIELD)
            `LAT_2: DATA_OUT_EN <= rd_pipe_q[0];
            `LAT_3: DATA_OUT_EN <= rd_pipe_q[1];
            default: DATA_OUT_EN <= 1'b0;
         endcase
      end
   end
endmodule // sdram_mode_ctrl

//--- tb/sdram_mode_ctrl_properties.sv
// concurrent checks on the pins of the mode controller
`include "sdram_mode_regs.vh"
module sdram_mode_checks
(
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic CKE,
   input wire logic CS_N,
   input wire logic RAS_N,
   input wire logic CAS_N,
   input wire logic WE_N,
   input wire logic [11:0] ADDRESS_PINS,
   input wire logic [11:0] SETTING_VALUE,
   input wire logic [2:0] BURST_COUNT_FIELD,
   input wire logic BURST_ORDER_FIELD,
   input wire logic [2:0] READ_LATENCY_FIELD,
   input wire logic [3:0] WRITE_MODE_FIELD,
   input wire logic [1:0] BANK_OPEN,
   input wire logic COL_VALID,
   input wire logic [7:0] COL_ADDR,
   input wire logic DATA_OUT_EN
);
   timeunit 1ns;
   timeprecision 1ps;
   // decoded command; only taken with chip selected and clock gate high
   wire [2:0] cmd = {RAS_N, CAS_N, WE_N};
   wire go = !CS_N && CKE;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);
   ////////////////////////////////////////////////////////////////////////
   // setting latch
   property p_mode;
      go && cmd == `CMD_MODE && BANK_OPEN == 2'h0 |=> SETTING_VALUE == $past(ADDRESS_PINS);
   endproperty
   a_mode: assert property (p_mode) else $error("setting not taken");
   property p_start;
      go && (cmd == `CMD_READ || cmd == `CMD_WRITE) |-> ##2 COL_VALID && COL_ADDR == $past(ADDRESS_PINS[7:0], 2);
   endproperty
   a_start: assert property (p_start) else $error("bad first column");
   property p_lat2;
      go && cmd == `CMD_READ && READ_LATENCY_FIELD == `LAT_2 |-> ##2 !DATA_OUT_EN ##1 DATA_OUT_EN;
   endproperty
   a_lat2: assert property (p_lat2) else $error("latency two wrong");
   property p_lat3;
      go && cmd == `CMD_READ && READ_LATENCY_FIELD == `LAT_3 |-> ##3 !DATA_OUT_EN ##1 DATA_OUT_EN;
   endproperty
   a_lat3: assert property (p_lat3) else $error("latency three wrong");
   property p_single;
      go && cmd == `CMD_WRITE && WRITE_MODE_FIELD[3:1] == `WM_SINGLE |-> ##2 COL_VALID ##1 !COL_VALID;
   endproperty
   a_single: assert property (p_single) else $error("single write not one beat");
   property p_burst4;
      go && cmd == `CMD_WRITE && WRITE_MODE_FIELD[3:1] == `WM_BURST && BURST_COUNT_FIELD == `BL_4
         |-> ##2 COL_VALID [*4] ##1 !COL_VALID;
   endproperty
   a_burst4: assert property (p_burst4) else $error("burst write not four beats");
   property p_seq;
      COL_VALID && $past(COL_VALID) && !BURST_ORDER_FIELD && BURST_COUNT_FIELD == `BL_8
         && !$past(go && (cmd == `CMD_READ || cmd == `CMD_WRITE), 2)
         |-> COL_ADDR[2:0] == $past(COL_ADDR[2:0]) + 3'h1;
   endproperty
   a_seq: assert property (p_seq) else $error("sequential order broken");
   property p_pre;
      go && cmd == `CMD_PRE |=> BANK_OPEN == ($past(ADDRESS_PINS[10]) ? 2'h0
         : $past(BANK_OPEN) & ~(2'h1 << $past(ADDRESS_PINS[11])));
   endproperty
   a_pre: assert property (p_pre) else $error("precharge closed wrong bank");
endmodule // sdram_mode_checks

//--- tb/ctrl_model.sv
// controller model: power-on sequence, then bench commands pass through
`include "sdram_mode_regs.vh"
module ctrl_model
#(
   parameter HOLD = 22
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic mode_first,
   input wire logic [11:0] setting,
   input wire logic [2:0] u_cmd,
   input wire logic [11:0] u_addr,
   output logic cke,
   output logic cs_n,
   output logic [2:0] cmd,
   output logic [11:0] addr,
   output logic rdy
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   logic [2:0] c;
   // edges since reset release
   always @(posedge clk or negedge arst_n)
      cnt <= arst_n ? cnt + 1 : 0;
   // init order
   // slots three apart keep the gap after a mode load; idle address toggles
   always_comb
   begin
      rdy = cnt > HOLD + 11;
      c = cnt == HOLD ? `CMD_PRE : cnt == HOLD + 6 ? `CMD_REF : `CMD_NOP;
      if (cnt == HOLD + 3)
         c = mode_first ? `CMD_MODE : `CMD_REF;
      if (cnt == HOLD + 9)
         c = mode_first ? `CMD_REF : `CMD_MODE;
      cmd = rdy ? u_cmd : c;
      addr = rdy ? u_addr : c == `CMD_MODE ? setting : c == `CMD_PRE ? 12'h400 : {12{cnt[0]}};
      cke = 1'b1;
      cs_n = 1'b0;
   end
endmodule // ctrl_model

//--- tb/sdram_init_and_mode_setup_bench.sv
// self-checking bench for the sdram mode controller
`include "sdram_mode_regs.vh"
module sdram_init_and_mode_setup_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic mf = 1'b0;
   logic [2:0] u_cmd = `CMD_NOP;
   logic [11:0] u_addr = 12'h000;
   wire cke, cs_n, rdy, done, order, valid, seq_err, cwr, cbank;
   wire [2:0] cmd, blen, lat;
   wire [3:0] wm;
   wire [1:0] banks;
   wire [7:0] col;
   wire [11:0] addr, setting;
   int err_count = 0;
   int compares = 0;
   int cycles = 0;
   // 100 MHz clock
   always #5 clk = ~clk;
   ctrl_model #(.HOLD(22)) u_ctl (.clk(clk), .arst_n(arst_n), .mode_first(mf), .setting(12'h032),
      .u_cmd(u_cmd), .u_addr(u_addr), .cke(cke), .cs_n(cs_n), .cmd(cmd), .addr(addr), .rdy(rdy));
   sdram_mode_ctrl #(.HOLD_CYCLES(20)) u_dut (.CLK(clk), .ARST_N(arst_n), .CKE(cke), .CS_N(cs_n),
      .RAS_N(cmd[2]), .CAS_N(cmd[1]), .WE_N(cmd[0]), .ADDRESS_PINS(addr), .INIT_DONE(done),
      .SETTING_VALUE(setting), .BURST_COUNT_FIELD(blen), .BURST_ORDER_FIELD(order),
      .READ_LATENCY_FIELD(lat), .WRITE_MODE_FIELD(wm), .BANK_OPEN(banks), .COL_VALID(valid),
      .COL_WRITE(cwr), .COL_BANK(cbank), .COL_ADDR(col), .DATA_OUT_EN(), .SEQ_ERROR(seq_err));
   ////////////////////////////////////////////////////////////////////////
   task check(input string name, input logic [11:0] seen, input logic [11:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task stop_test;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // one command for one cycle, then n idle cycles; idle address inverted
   task send(input logic [2:0] c, input logic [11:0] a, input int n);
      @(posedge clk);
      u_cmd <= c;
      u_addr <= a;
      @(posedge clk);
      u_cmd <= `CMD_NOP;
      u_addr <= ~a;
      repeat (n) @(posedge clk);
   endtask
   // mode load with banks idle, a write, then the read column order
   task run(input logic [11:0] m, input logic [7:0] c);
      logic [7:0] e;
      int len;
      logic b;
      len = m[2:0] == `BL_8 ? 8 : 4;
      b = c[1];
      send(`CMD_PRE, 12'h400, 1);
      send(`CMD_MODE, m, 3);
      check("setting", setting, m);
      check("fields", {wm, 1'b0, lat, order, blen}, {m[11:8], 1'b0, m[6:0]});
      send(`CMD_ACT, {b, 11'h000}, 1);
      // first write beat shows the command's column and bank one edge later
      send(`CMD_WRITE, {b, 3'h0, c}, 0);
      @(posedge clk);
      #1;
      check("write beat", {cbank, cwr, 1'b0, valid, col}, {b, 1'b1, 1'b0, 1'b1, c});
      repeat (8) @(posedge clk);
      send(`CMD_READ, {b, 3'h0, c}, 0);
      for (int k = 0; k < len; k++)
      begin
         @(posedge clk);
         #1;
         e = m[3] ? c ^ k[7:0] : (c & ~(len[7:0] - 8'h1)) | ((c + k[7:0]) & (len[7:0] - 8'h1));
         check("column", {cbank, cwr, 1'b0, valid, col}, {b, 2'b00, 1'b1, e});
      end
      @(posedge clk);
      #1;
      check("burst end", {11'h0, valid}, 12'h000);
   endtask
   // both init orders, three mode settings, single-bank precharge
   initial
   begin
      for (int p = 0; p < 2; p++)
      begin
         @(posedge clk);
         arst_n <= 1'b0;
         mf <= p[0];
         repeat (6) @(posedge clk);
         arst_n <= 1'b1;
         while (!rdy) @(posedge clk);
         #1;
         check("init", {11'h0, done}, 12'h001);
         check("setting", setting, 12'h032);
      end
      run(12'h032, 8'h05);
      run(12'h12A, 8'h05);
      run(12'h833, 8'h03);
      // bank 1 is still open from the last run; open bank 0, close bank 1
      send(`CMD_ACT, 12'h000, 1);
      send(`CMD_PRE, 12'h800, 1);
      check("banks", {10'h0, banks}, 12'h001);
      check("sequence error", {11'h0, seq_err}, 12'h000);
      // a command two cycles after a mode load must raise the sticky flag
      send(`CMD_PRE, 12'h400, 1);
      send(`CMD_MODE, 12'h032, 0);
      send(`CMD_PRE, 12'h400, 1);
      check("gap error", {11'h0, seq_err}, 12'h001);
      stop_test;
   end
   // hang guard; the run needs a few hundred cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_count++;
         stop_test;
      end
   end
endmodule // sdram_init_and_mode_setup_bench
bind sdram_mode_ctrl sdram_mode_checks u_chk (.*);
